// ==== core/mms_pkg.sv ====
// Shared constants and types for the module management status timing block
package mms_pkg;

	// Clock period of the block clock in nanoseconds
	localparam int unsigned CLK_PERIOD_NS  = 5;
	// Nanoseconds in one microsecond
	localparam int unsigned NS_PER_US      = 1000;
	// Block clock cycles per microsecond tick
	localparam int unsigned CYC_PER_US     = NS_PER_US / CLK_PERIOD_NS;
	// Terminal value of the microsecond prescaler
	localparam logic [7:0]  US_CNT_MAX     = 8'(CYC_PER_US - 1);
	// Microsecond ticks per millisecond tick
	localparam int unsigned US_PER_MS_DFLT = 1000;

	// Longest times the block may take, in their own units, except T_RESET_MIN_US, the minimum restart pulse
	localparam int unsigned T_INIT_MS      = 2000;
	localparam int unsigned T_RESET_MIN_US = 2;
	localparam int unsigned T_LP_US        = 100;
	localparam int unsigned T_INT_ON_MS    = 200;
	localparam int unsigned T_INT_OFF_US   = 500;
	localparam int unsigned T_LOS_MS       = 100;
	localparam int unsigned T_TXF_MS       = 200;
	localparam int unsigned T_MASK_MS      = 100;
	localparam int unsigned T_SEL_US       = 100;
	localparam int unsigned T_PDN_MS       = 100;
	localparam int unsigned T_PUP_MS       = 300;

	// Start-up duration in ms ticks, half of the allowed limit
	localparam int unsigned INIT_MS_DFLT   = T_INIT_MS / 2;
	// Restart pin low filter in us ticks, one above the minimum pulse
	localparam logic [1:0]  RST_FILT_US    = 2'(T_RESET_MIN_US + 1);

	// Flag vector layout
	localparam int N_CH         = 4;
	localparam int FLAG_W       = 10;
	localparam int FLAG_LOS_LSB = 0;
	localparam int FLAG_TXF_LSB = 4;
	localparam int FLAG_OTHER   = 8;
	localparam int FLAG_READY   = 9;

	// Values after reset
	localparam logic [FLAG_W-1:0] FLAGS_RST = 10'h000;
	localparam logic [FLAG_W-1:0] MASK_RST  = 10'h000;

	// Start-up sequencer states
	typedef enum logic [2:0] {
		MMS_HOLD = 3'h1,
		MMS_INIT = 3'h2,
		MMS_RUN  = 3'h4
	} mms_state_t;

endpackage : mms_pkg

// ==== core/mms_twi_if.sv ====
// Two-wire bus observation signals between the top and the bus watcher
`timescale 1ns/1ps
`default_nettype none
interface mms_twi_if;
	logic scl;      // Raw bus clock pin level
	logic sda;      // Raw bus data pin level
	logic stopFall; // Pulse on first clock fall after a stop
	modport watcher (input scl, input sda, output stopFall);
	modport user    (output scl, output sda, input stopFall);
endinterface : mms_twi_if
`default_nettype wire

// ==== core/mms_twi_watch.sv ====
// Bus watcher that marks the first clock fall after a stop condition
`timescale 1ns/1ps
`default_nettype none
module mms_twi_watch (
	input  wire logic   clk,
	input  wire logic   rst,
	mms_twi_if.watcher  twi
);
	import mms_pkg::*;

	logic sclMeta_r;    // First synchroniser stage, clock
	logic sclSync_r;    // Second synchroniser stage, clock
	logic sclPrev_r;    // Delayed clock for edges
	logic sdaMeta_r;    // First synchroniser stage, data
	logic sdaSync_r;    // Second synchroniser stage, data
	logic sdaPrev_r;    // Delayed data for edges
	logic armed_r;      // Stop seen, waiting for clock fall
	logic stopFall_r;   // Output pulse
	logic stopSeen;     // Data rises while clock high
	logic startSeen;    // Data falls while clock high
	logic sclFall;      // Clock falling edge

	// Two-stage synchronisers for both pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclMeta_r <= 1'b1;
			sclSync_r <= 1'b1;
			sclPrev_r <= 1'b1;
			sdaMeta_r <= 1'b1;
			sdaSync_r <= 1'b1;
			sdaPrev_r <= 1'b1;
		end else begin
			sclMeta_r <= twi.scl;
			sclSync_r <= sclMeta_r;
			sclPrev_r <= sclSync_r;
			sdaMeta_r <= twi.sda;
			sdaSync_r <= sdaMeta_r;
			sdaPrev_r <= sdaSync_r;
		end
	end

	// Bus condition decode on synchronised levels
	assign stopSeen  = sclSync_r & sclPrev_r & sdaSync_r & ~sdaPrev_r;
	assign startSeen = sclSync_r & sclPrev_r & ~sdaSync_r & sdaPrev_r;
	assign sclFall   = ~sclSync_r & sclPrev_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			armed_r    <= 1'b0;
			stopFall_r <= 1'b0;
		end else begin
			stopFall_r <= armed_r & sclFall;
			if (stopSeen) begin
				armed_r <= 1'b1;
			end else if (sclFall || startSeen) begin
				armed_r <= 1'b0;
			end
		end
	end

	assign twi.stopFall = stopFall_r;

	// Watcher pulses one cycle after the clock fall that follows a stop
	AST_STOP_FALL: assert property (@(posedge clk) disable iff (rst)
		(armed_r && sclFall) |=> stopFall_r ##1 !stopFall_r)
		else $error("stop-fall pulse missing or too long");

endmodule : mms_twi_watch
`default_nettype wire

// ==== core/mms_top.sv ====
// Management side start-up, interrupt, select and low-power timing logic
`timescale 1ns/1ps
`default_nettype none
module mms_top #(
	parameter int unsigned US_PER_MS = mms_pkg::US_PER_MS_DFLT, // us ticks per ms tick
	parameter int unsigned INIT_MS   = mms_pkg::INIT_MS_DFLT    // start-up length in ms
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       hardRestartInN,
	input  wire logic                       lowPowerRequest,
	input  wire logic                       moduleSelectN,
	input  wire logic                       twScl,
	input  wire logic                       twSda,
	input  wire logic [mms_pkg::N_CH-1:0]   losCond,
	input  wire logic [mms_pkg::N_CH-1:0]   txFaultCond,
	input  wire logic                       otherCond,
	input  wire logic                       flagReadStb,
	input  wire logic [mms_pkg::FLAG_W-1:0] flagReadSel,
	input  wire logic                       maskWrStb,
	input  wire logic [mms_pkg::FLAG_W-1:0] maskWrData,
	input  wire logic                       pdnWrStb,
	input  wire logic                       pdnWrData,
	output logic                            interruptOutN,
	output logic                            interruptOutOe,
	output logic [mms_pkg::FLAG_W-1:0]      flagsOut,
	output logic                            dataNotReady,
	output logic                            busRespondEn,
	output logic                            lowPowerActive,
	output logic                            fullyFunctional
);
	import mms_pkg::*;

	// Unmasked flag sources, used by the driver and by checks
	function automatic logic intSource(input logic [FLAG_W-1:0] fl, input logic [FLAG_W-1:0] mk);
		intSource = |(fl & ~mk);
	endfunction : intSource

	mms_twi_if twLink ();                    // Bus watcher link

	logic [7:0]        usCnt_r;              // Cycle prescaler
	logic              usTick_r;             // One pulse per microsecond
	logic [9:0]        msCnt_r;              // Microsecond counter
	logic              msTick_r;             // One pulse per millisecond
	logic [10:0]       initCnt_r;            // Start-up ms counter
	logic [1:0]        lowUs_r;              // Restart low duration, us
	mms_state_t        state_r;              // Start-up sequencer
	mms_state_t        state_nxt;            // Next sequencer state
	logic              initDoneNow;          // Start-up finishes this cycle
	logic [2:0]        pinMeta_r;            // First stage: restart, lp, select
	logic [2:0]        pinSync_r;            // Second stage of same
	logic              restartSync;          // Synced restart pin
	logic              lpSync;               // Synced low power request
	logic              selSync;              // Synced select, active high
	logic [FLAG_W-1:0] condMeta_r;           // First stage of conditions
	logic [FLAG_W-1:0] condSync_r;           // Second stage of conditions
	logic [FLAG_W-1:0] condPrev_r;           // Delayed conditions
	logic [FLAG_W-1:0] condRaw;              // Condition vector in flag layout
	logic [FLAG_W-1:0] condRise;             // New condition events
	logic [FLAG_W-1:0] flags_r;              // Latched flags
	logic [FLAG_W-1:0] flags_nxt;            // Next flags
	logic [FLAG_W-1:0] clrPend_r;            // Flags read, awaiting release
	logic [FLAG_W-1:0] clrNow;               // Clear applied this cycle
	logic [FLAG_W-1:0] maskPendVal_r;        // Mask written, not yet active
	logic              maskPend_r;           // Mask write pending
	logic [FLAG_W-1:0] maskEff_r;            // Active mask
	logic              pdnPendVal_r;         // Power-down written value
	logic              pdnPend_r;            // Power-down write pending
	logic              pdnEff_r;             // Active power-down bit
	logic              dataNotReady_r;       // Not-ready status bit
	logic              intN_r;               // Interrupt pin level
	logic              intOe_r;              // Interrupt pin driven low
	logic              busEn_r;              // Bus answers allowed
	logic              lowPower_r;           // Low power level active
	logic              fullFunc_r;           // Fully functional status
	logic              linkDone;             // Fall after stop, from watcher

	// Watcher sees the raw pins and returns the transaction end mark
	assign twLink.scl = twScl;
	assign twLink.sda = twSda;
	assign linkDone   = twLink.stopFall;

	mms_twi_watch uWatch (
		.clk (clk),
		.rst (rst),
		.twi (twLink.watcher)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			usCnt_r  <= 8'h00;
			usTick_r <= 1'b0;
			msCnt_r  <= 10'h000;
			msTick_r <= 1'b0;
		end else begin
			usTick_r <= (usCnt_r == US_CNT_MAX);
			usCnt_r  <= (usCnt_r == US_CNT_MAX) ? 8'h00 : usCnt_r + 8'h01;
			msTick_r <= usTick_r && (msCnt_r == 10'(US_PER_MS - 1));
			if (usTick_r) begin
				msCnt_r <= (msCnt_r == 10'(US_PER_MS - 1)) ? 10'h000 : msCnt_r + 10'h001;
			end
		end
	end

	// Two-stage synchronisers for the control pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinMeta_r <= 3'h1;
			pinSync_r <= 3'h1;
		end else begin
			pinMeta_r <= {~moduleSelectN, lowPowerRequest, hardRestartInN};
			pinSync_r <= pinMeta_r;
		end
	end

	assign restartSync = pinSync_r[0];
	assign lpSync      = pinSync_r[1];
	assign selSync     = pinSync_r[2];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lowUs_r <= 2'h0;
		end else if (restartSync) begin
			lowUs_r <= 2'h0;
		end else if (usTick_r && lowUs_r != RST_FILT_US) begin
			lowUs_r <= lowUs_r + 2'h1;
		end
	end

	// start-up completes on the ms count
	assign initDoneNow = (state_r == MMS_INIT) && msTick_r && (initCnt_r == 11'(INIT_MS - 1));

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			MMS_HOLD: begin
				if (restartSync) begin
					state_nxt = MMS_INIT;
				end
			end
			MMS_INIT: begin
				if (initDoneNow) begin
					state_nxt = MMS_RUN;
				end
			end
			MMS_RUN: begin
				state_nxt = MMS_RUN;
			end
			default: begin
				state_nxt = MMS_HOLD;
			end
		endcase
		// A qualified low pulse restarts from any state
		if (!restartSync && lowUs_r == RST_FILT_US) begin
			state_nxt = MMS_HOLD;
		end
	end

	// Sequencer register and start-up counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r   <= MMS_INIT;
			initCnt_r <= 11'h000;
		end else begin
			state_r <= state_nxt;
			if (state_r != MMS_INIT) begin
				initCnt_r <= 11'h000;
			end else if (msTick_r) begin
				initCnt_r <= initCnt_r + 11'h001;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dataNotReady_r <= 1'b1;
		end else if (state_nxt == MMS_HOLD) begin
			dataNotReady_r <= 1'b1;
		end else if (initDoneNow) begin
			dataNotReady_r <= 1'b0;
		end
	end

	// Condition pins synchronised into flag layout
	assign condRaw = {1'b0, otherCond, txFaultCond, losCond};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			condMeta_r <= FLAGS_RST;
			condSync_r <= FLAGS_RST;
			condPrev_r <= FLAGS_RST;
		end else begin
			condMeta_r <= condRaw;
			condSync_r <= condMeta_r;
			condPrev_r <= condSync_r;
		end
	end

	// ready event joins the condition events
	always_comb begin
		condRise             = condSync_r & ~condPrev_r;
		condRise[FLAG_READY] = initDoneNow;
	end

	// read clears wait for the transaction end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clrPend_r <= FLAGS_RST;
		end else if (linkDone) begin
			clrPend_r <= flagReadStb ? flagReadSel : FLAGS_RST;
		end else if (flagReadStb) begin
			clrPend_r <= clrPend_r | flagReadSel;
		end
	end

	assign clrNow = linkDone ? clrPend_r : FLAGS_RST;

	genvar gi;
	generate
		for (gi = 0; gi < FLAG_W; gi = gi + 1) begin : gFlag
			always_comb begin
				flags_nxt[gi] = (flags_r[gi] & ~clrNow[gi]) | condRise[gi] | (clrNow[gi] & condSync_r[gi]);
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_r <= FLAGS_RST;
		end else if (state_r == MMS_HOLD) begin
			flags_r <= FLAGS_RST;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// mask takes effect after the write ends
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			maskPend_r    <= 1'b0;
			maskPendVal_r <= MASK_RST;
			maskEff_r     <= MASK_RST;
		end else if (state_r == MMS_HOLD) begin
			maskPend_r    <= 1'b0;
			maskPendVal_r <= MASK_RST;
			maskEff_r     <= MASK_RST;
		end else begin
			if (maskWrStb) begin
				maskPendVal_r <= maskWrData;
			end
			if (linkDone && maskPend_r) begin
				maskEff_r <= maskPendVal_r;
			end
			// A write landing with the end mark waits for the next end
			maskPend_r <= maskWrStb | (maskPend_r & ~linkDone);
		end
	end

	// power-down bit after the write ends
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pdnPend_r    <= 1'b0;
			pdnPendVal_r <= 1'b0;
			pdnEff_r     <= 1'b0;
		end else if (state_r == MMS_HOLD) begin
			pdnPend_r    <= 1'b0;
			pdnPendVal_r <= 1'b0;
			pdnEff_r     <= 1'b0;
		end else begin
			if (pdnWrStb) begin
				pdnPendVal_r <= pdnWrData;
			end
			if (linkDone && pdnPend_r) begin
				pdnEff_r <= pdnPendVal_r;
			end
			pdnPend_r <= pdnWrStb | (pdnPend_r & ~linkDone);
		end
	end

	// low power from pin or bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lowPower_r <= 1'b0;
			fullFunc_r <= 1'b0;
		end else begin
			lowPower_r <= lpSync | pdnEff_r;
			fullFunc_r <= (state_r == MMS_RUN) && !dataNotReady_r && !lowPower_r;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			intN_r  <= 1'b1;
			intOe_r <= 1'b0;
		end else begin
			intN_r  <= ~intSource(flags_r, maskEff_r);
			intOe_r <= intSource(flags_r, maskEff_r);
		end
	end

	// bus answers only when ready and selected
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busEn_r <= 1'b0;
		end else begin
			busEn_r <= (state_r == MMS_RUN) && selSync;
		end
	end

	// Outputs straight from registers
	assign interruptOutN   = intN_r;
	assign interruptOutOe  = intOe_r;
	assign flagsOut        = flags_r;
	assign dataNotReady    = dataNotReady_r;
	assign busRespondEn    = busEn_r;
	assign lowPowerActive  = lowPower_r;
	assign fullyFunctional = fullFunc_r;

	// Start-up end clears not-ready and raises the ready flag
	AST_INIT_DONE: assert property (@(posedge clk) disable iff (rst)
		(initDoneNow && state_nxt != MMS_HOLD) |=> (state_r == MMS_RUN && !dataNotReady_r && flags_r[FLAG_READY]) ##1 !intN_r)
		else $error("start-up end did not report ready");

	// A qualified restart pulse holds the block
	AST_RST_FILTER: assert property (@(posedge clk) disable iff (rst)
		(!restartSync && lowUs_r == RST_FILT_US) |=> (state_r == MMS_HOLD && dataNotReady_r))
		else $error("restart pulse not taken");

	// Select gates bus answers in both directions
	AST_BUS_GATE: assert property (@(posedge clk) disable iff (rst)
		(state_r == MMS_RUN && selSync) |=> busEn_r)
		else $error("selected module not answering");

	AST_BUS_DROP: assert property (@(posedge clk) disable iff (rst)
		!selSync |=> !busEn_r)
		else $error("deselected module still answering");

	// Low power pin reaches the power level next cycle
	AST_LP_ENTER: assert property (@(posedge clk) disable iff (rst)
		lpSync |=> lowPower_r)
		else $error("low power request ignored");

	// Any unmasked flag pulls the pin low, none releases it
	AST_INT_LOW: assert property (@(posedge clk) disable iff (rst)
		intSource(flags_r, maskEff_r) |=> (!intN_r && intOe_r))
		else $error("interrupt not asserted");

	AST_INT_REL: assert property (@(posedge clk) disable iff (rst)
		!intSource(flags_r, maskEff_r) |=> (intN_r && !intOe_r))
		else $error("interrupt not released");

	// Condition events latch their flags
	AST_FLAG_SET: assert property (@(posedge clk) disable iff (rst)
		(|condRise && state_r != MMS_HOLD) |=> ((flags_r & $past(condRise)) == $past(condRise)))
		else $error("flag not set on condition");

	// Mask written becomes active at the transaction end
	AST_MASK_APPLY: assert property (@(posedge clk) disable iff (rst)
		(linkDone && maskPend_r && state_r != MMS_HOLD) |=> (maskEff_r == $past(maskPendVal_r)))
		else $error("mask not applied at transaction end");

	// Power-down bit reaches the power level two cycles after the end
	AST_PDN_ENTER: assert property (@(posedge clk) disable iff (rst)
		(linkDone && pdnPend_r && pdnPendVal_r && state_r != MMS_HOLD) |=> ##1 lowPower_r)
		else $error("power-down not entered");

	// Flags never drop except at a transaction end or a hold
	AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (rst)
		(state_r != MMS_HOLD && !linkDone) |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
		else $error("flag dropped without read");

endmodule : mms_top
`default_nettype wire

// ==== testbench/mms_host_model.sv ====
// Host controller model: module pins and two-wire bus frames with their end marks
`timescale 1ns/1ps
`default_nettype none
module mms_host_model (
	input  wire logic clk,
	output logic      twScl,
	output logic      twSda,
	output logic      moduleSelectN,
	output logic      lowPowerRequest,
	output logic      hardRestartInN
);
	// Half period of the 48 ns bus clock
	localparam int HALF_NS = 24;

	// Bus idles high on its pull-ups; module selected, awake, not restarting
	initial begin
		twScl = 1'b1;
		twSda = 1'b1;
		moduleSelectN = 1'b0;
		lowPowerRequest = 1'b0;
		hardRestartInN = 1'b1;
	end

	// Short frame, stop condition, then the bus clock fall that ends the transfer
	task automatic endMark();
		int i;
		// Step off the block clock edge before touching the pins
		#1;
		twSda = 1'b0;
		#HALF_NS;
		for (i = 0; i < 4; i++) begin
			twScl = 1'b0;
			twSda = i[0];
			#HALF_NS;
			twScl = 1'b1;
			#HALF_NS;
		end
		twScl = 1'b0;
		twSda = 1'b0;
		#HALF_NS;
		twScl = 1'b1;
		#HALF_NS;
		twSda = 1'b1;
		#HALF_NS;
		twScl = 1'b0;
		#HALF_NS;
		// Clock stands high again between frames
		twScl = 1'b1;
	endtask : endMark

	// restart pin held low for the given clock count
	task automatic restartPulse(input int cycles);
		@(posedge clk);
		hardRestartInN <= 1'b0;
		repeat (cycles) @(posedge clk);
		hardRestartInN <= 1'b1;
	endtask : restartPulse

	// Select pin change, launched on a clock edge
	task automatic setSelect(input logic v);
		@(posedge clk);
		moduleSelectN <= v;
	endtask : setSelect

	// Low power pin change, launched on a clock edge
	task automatic setLowPower(input logic v);
		@(posedge clk);
		lowPowerRequest <= v;
	endtask : setLowPower
endmodule : mms_host_model
`default_nettype wire

// ==== testbench/mms_top_tb.sv ====
// Self-checking testbench for the management status timing block
`timescale 1ns/1ps
`default_nettype none
module mms_top_tb;
	import mms_pkg::*;
	localparam int US_MS = 2;          // us ticks per ms tick in simulation
	localparam int INIT  = 3;          // start-up length in ms ticks
	localparam int T_UP  = (INIT + 1) * US_MS * 200 + 20; // start-up bound in cycles
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic twScl, twSda, selN, lpReq, rstInN;
	logic [8:0] condVec;               // Conditions: los, tx fault, other
	logic flagReadStb;                 // Read strobe to the block
	logic [FLAG_W-1:0] flagReadSel;    // Flags named by a read
	logic maskWrStb;                   // Mask write strobe
	logic [FLAG_W-1:0] maskWrData;     // Mask write value
	logic pdnWrStb;                    // Power-down write strobe
	logic pdnWrData;                   // Power-down write value
	logic intN, intOe, notReady, busEn, lowPow, funcOk;
	logic [FLAG_W-1:0] flags;
	int n_mismatch = 0;
	int n_tests = 0;

	// 200 MHz block clock
	always #2.5 clk = ~clk;

	mms_host_model mms_host_model_inst (.clk(clk), .twScl(twScl), .twSda(twSda),
		.moduleSelectN(selN), .lowPowerRequest(lpReq), .hardRestartInN(rstInN));

	mms_top #(.US_PER_MS(US_MS), .INIT_MS(INIT)) mms_top_inst (.clk(clk), .rst(rst),
		.hardRestartInN(rstInN), .lowPowerRequest(lpReq), .moduleSelectN(selN), .twScl(twScl),
		.twSda(twSda), .losCond(condVec[3:0]), .txFaultCond(condVec[7:4]), .otherCond(condVec[8]),
		.flagReadStb(flagReadStb), .flagReadSel(flagReadSel), .maskWrStb(maskWrStb),
		.maskWrData(maskWrData), .pdnWrStb(pdnWrStb), .pdnWrData(pdnWrData),
		.interruptOutN(intN), .interruptOutOe(intOe), .flagsOut(flags), .dataNotReady(notReady),
		.busRespondEn(busEn), .lowPowerActive(lowPow), .fullyFunctional(funcOk));

	// Compare one value, report and count
	task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// Pick an output by number: 0 int, 1 not ready, 2 bus, 3 low power, 4 functional
	function automatic logic probe(input int k);
		case (k)
			0: return intN;
			1: return notReady;
			2: return busEn;
			3: return lowPow;
			default: return funcOk;
		endcase
	endfunction : probe

	// Wait for an output to reach a value within a bound, then compare it
	task automatic waitVal(input string name, input int k, input logic v, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge clk);
			#1;
			if (probe(k) === v) break;
		end
		check(name, {9'h000, v}, {9'h000, probe(k)});
		if (k == 0) check("interruptOutOe", {9'h000, ~v}, {9'h000, intOe});
	endtask : waitVal

	// Read strobe for the selected flags, closed by a bus end mark
	task automatic readClear(input logic [9:0] sel);
		@(posedge clk);
		flagReadStb <= 1'b1;
		flagReadSel <= sel;
		@(posedge clk);
		flagReadStb <= 1'b0;
		mms_host_model_inst.endMark();
	endtask : readClear

	// Mask or power-down write, closed by a bus end mark
	task automatic regWrite(input logic isPdn, input logic [9:0] d);
		@(posedge clk);
		maskWrStb <= ~isPdn;
		pdnWrStb <= isPdn;
		maskWrData <= d;
		pdnWrData <= d[0];
		@(posedge clk);
		maskWrStb <= 1'b0;
		pdnWrStb <= 1'b0;
		mms_host_model_inst.endMark();
	endtask : regWrite

	// Start-up: quiet outputs, then not-ready clear, ready flag and interrupt
	task automatic testStartup();
		check("dataNotReady", 10'h001, {9'h000, notReady});
		check("busRespondEn", 10'h000, {9'h000, busEn});
		check("interruptOutN", 10'h001, {9'h000, intN});
		waitVal("dataNotReady", 1, 1'b0, T_UP);
		check("flagsOut", 10'h200, flags);
		waitVal("interruptOutN", 0, 1'b0, 3);
		waitVal("busRespondEn", 2, 1'b1, 3);
		waitVal("fullyFunctional", 4, 1'b1, 3);
		readClear(10'h200);
		waitVal("interruptOutN", 0, 1'b1, 40);
		check("flagsOut", 10'h000, flags);
		$display("test startup done");
	endtask : testStartup

	// Every condition sets its own flag and interrupt, read clears it
	task automatic testConditions();
		int i;
		for (i = 0; i < 9; i++) begin
			@(posedge clk);
			condVec <= 9'(1 << i);
			waitVal("interruptOutN", 0, 1'b0, 20);
			check("flagsOut", 10'(1 << i), flags);
			@(posedge clk);
			condVec <= 9'h000;
			readClear(10'(1 << i));
			waitVal("interruptOutN", 0, 1'b1, 40);
			check("flagsOut", 10'h000, flags);
		end
		// A read while the condition persists leaves the flag set
		@(posedge clk);
		condVec <= 9'h100;
		readClear(10'h100);
		repeat (10) @(posedge clk);
		check("flagsOut", 10'h100, flags);
		check("interruptOutN", 10'h000, {9'h000, intN});
		@(posedge clk);
		condVec <= 9'h000;
		readClear(10'h100);
		waitVal("interruptOutN", 0, 1'b1, 40);
		$display("test conditions done");
	endtask : testConditions

	// Masked flag latches silently; unmasking lets the interrupt through
	task automatic testMask();
		regWrite(1'b0, 10'h100);
		repeat (5) @(posedge clk);
		condVec <= 9'h100;
		repeat (12) @(posedge clk);
		check("flagsOut", 10'h100, flags);
		check("interruptOutN", 10'h001, {9'h000, intN});
		regWrite(1'b0, 10'h000);
		waitVal("interruptOutN", 0, 1'b0, 20);
		@(posedge clk);
		condVec <= 9'h000;
		readClear(10'h100);
		waitVal("interruptOutN", 0, 1'b1, 40);
		$display("test mask done");
	endtask : testMask

	// Select pin gates bus answers both ways
	task automatic testSelect();
		mms_host_model_inst.setSelect(1'b1);
		waitVal("busRespondEn", 2, 1'b0, 10);
		mms_host_model_inst.setSelect(1'b0);
		waitVal("busRespondEn", 2, 1'b1, 10);
		$display("test select done");
	endtask : testSelect

	// Low power through the pin and through the power-down bit
	task automatic testPower();
		mms_host_model_inst.setLowPower(1'b1);
		waitVal("lowPowerActive", 3, 1'b1, 10);
		waitVal("fullyFunctional", 4, 1'b0, 3);
		mms_host_model_inst.setLowPower(1'b0);
		waitVal("fullyFunctional", 4, 1'b1, 10);
		regWrite(1'b1, 10'h001);
		waitVal("lowPowerActive", 3, 1'b1, 20);
		waitVal("fullyFunctional", 4, 1'b0, 3);
		regWrite(1'b1, 10'h000);
		waitVal("fullyFunctional", 4, 1'b1, 20);
		$display("test power done");
	endtask : testPower

	// Short restart low is ignored, a long one restarts the start-up
	task automatic testRestart();
		mms_host_model_inst.restartPulse(300);
		repeat (800) @(posedge clk);
		check("dataNotReady", 10'h000, {9'h000, notReady});
		mms_host_model_inst.restartPulse(1000);
		#1;
		check("dataNotReady", 10'h001, {9'h000, notReady});
		check("busRespondEn", 10'h000, {9'h000, busEn});
		check("flagsOut", 10'h000, flags);
		waitVal("dataNotReady", 1, 1'b0, T_UP);
		waitVal("interruptOutN", 0, 1'b0, 3);
		readClear(10'h200);
		waitVal("interruptOutN", 0, 1'b1, 40);
		$display("test restart done");
	endtask : testRestart

	// Counts and verdict, then stop
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	// Main sequence
	initial begin
		// Quiet strobes and conditions while reset is held
		condVec <= 9'h000;
		flagReadStb <= 1'b0;
		flagReadSel <= 10'h000;
		maskWrStb <= 1'b0;
		maskWrData <= 10'h000;
		pdnWrStb <= 1'b0;
		pdnWrData <= 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		testStartup();
		testConditions();
		testMask();
		testSelect();
		testPower();
		testRestart();
		finish_test();
	end

	// Watchdog well beyond the expected run of about 6000 cycles
	initial begin
		#400000;
		n_mismatch++;
		finish_test();
	end
endmodule : mms_top_tb
`default_nettype wire
